//--- include/phy_xover_pkg.sv
// Constants for the port PHY crossover control and event flag register bank.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers at four times the index.
package phy_xover_pkg;

    // ------------------------------------------------------------------
    // Register indices and bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [5:0] IDX_XOVER_CTRL = 6'h1b;
    localparam logic [5:0] IDX_EVENT_FLAGS = 6'h1d;
    localparam logic [5:0] IDX_EVENT_MASK = 6'h1e;

    // ------------------------------------------------------------------
    // Field positions in the crossover and misc control register
    // ------------------------------------------------------------------
    localparam int POS_XOVER_SOURCE_SELECT = 15;
    localparam int POS_XOVER_ENABLE = 14;
    localparam int POS_XOVER_STATE = 13;
    localparam int POS_HEARTBEAT_TEST_DISABLE = 11;
    localparam int POS_RX_PLL_FORCE_REF_LOCK = 10;
    localparam int POS_RX_POLARITY_REVERSED = 4;

    // ------------------------------------------------------------------
    // Event flag positions; bits 15:8 and 0 are reserved
    // ------------------------------------------------------------------
    localparam int FLAG_LO = 1;
    localparam int FLAG_HI = 7;
    localparam int POS_FLAG_PAGE_RECEIVED = 1;
    localparam int POS_FLAG_PARALLEL_DETECT_FAULT = 2;
    localparam int POS_FLAG_PARTNER_ACK = 3;
    localparam int POS_FLAG_LINK_DOWN = 4;
    localparam int POS_FLAG_REMOTE_FAULT = 5;
    localparam int POS_FLAG_AUTONEG_COMPLETE = 6;
    localparam int POS_FLAG_LINE_ENERGY = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic [6:0] RST_FLAGS = 7'h00;
    localparam logic [6:0] RST_MASK = 7'h00;

    // ------------------------------------------------------------------
    // Crossover modes driven to the analog switch
    // ------------------------------------------------------------------
    localparam logic [1:0] MDIX_STRAIGHT = 2'h0;
    localparam logic [1:0] MDIX_CROSS = 2'h1;
    localparam logic [1:0] MDIX_AUTO = 2'h2;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/phy_crossover_and_event_flags.sv
// Port PHY crossover/misc control register and latched clear-on-read event flags.
// Assumes synchronous inputs on core_clk, an AXI4-Lite master, and a port PHY reset pulse
// from the chip reset control.
//
// Summary of operation
// - Bit 15 selects register or strap crossover
// - State bit matters only under register control
// - Enable/state decode: straight, cross, automatic
// - Auto strap wins, else manual strap decides
// - Bit 11 resets 0; 1 disables heartbeat
// - Bit 10 forces 10M PLL reference lock
// - No 10M receive data while forced lock
// - Bit 4 shows reversed receive polarity
// - Port PHY reset restores retained control bits
// - Soft PHY reset leaves retained bits alone
// - Flags read-only, reset 0, latch until cleared
// - Reading index 29 clears all flags
// - Mask at index 30 gates each source
// - Flag 7 latches on line energy rising
// - Flag 6 latches on autoneg complete
// - Flag 5 latches on remote fault
// - Flag 4 latches on link going down
// - Flag 3 latches on partner acknowledge
// - Flag 2 latches on parallel detect fault
// - Flag 1 latches on page received
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
module phy_crossover_and_event_flags (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Port PHY reset from chip reset control, one-cycle pulse
    input wire logic port_phy_reset,
    // Straps and PHY status
    input wire logic auto_mdix_strap,
    input wire logic manual_mdix_strap,
    input wire logic rx_polarity_reversed_in,
    input wire logic line_energy_detect,
    input wire logic link_status,
    input wire logic autoneg_complete_evt,
    input wire logic remote_fault_evt,
    input wire logic partner_ack_evt,
    input wire logic parallel_detect_fault_evt,
    input wire logic page_received_evt,
    // 10M receive data path gate
    input wire logic rx10_valid_in,
    output logic rx10_valid_out,
    // PHY control outputs
    output logic [1:0] mdix_mode,
    output logic heartbeat_test_en,
    output logic rx_pll_ref_lock,
    // AXI4-Lite write address
    input wire logic [phy_xover_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [phy_xover_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic src_sel_r;
    logic xover_en_r;
    logic xover_state_r;
    logic hb_disable_r;
    logic pll_lock_r;
    logic [6:0] flags_r;
    logic [6:0] flags_nxt;
    logic [6:0] mask_r;
    logic energy_prev_r;
    logic link_prev_r;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic [phy_xover_pkg::ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [5:0] wr_idx;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_hit;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_idx = awaddr_r[phy_xover_pkg::ADDR_W-1:2];
    assign wr_ctrl = do_write && wr_idx == phy_xover_pkg::IDX_XOVER_CTRL && wstrb_r[1];
    assign wr_mask = do_write && wr_idx == phy_xover_pkg::IDX_EVENT_MASK && wstrb_r[0];
    assign wr_hit = wr_idx == phy_xover_pkg::IDX_XOVER_CTRL || wr_idx == phy_xover_pkg::IDX_EVENT_MASK
                    || wr_idx == phy_xover_pkg::IDX_EVENT_FLAGS;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= phy_xover_pkg::RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? phy_xover_pkg::RESP_OKAY : phy_xover_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Besides rst_n, only the port PHY reset from the chip reset control restores these bits; a soft
    // reset through the PHY basic control register is not an input here and leaves them.
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_sel_r <= phy_xover_pkg::RST_CTRL_BIT;
            xover_en_r <= phy_xover_pkg::RST_CTRL_BIT;
            xover_state_r <= phy_xover_pkg::RST_CTRL_BIT;
            hb_disable_r <= phy_xover_pkg::RST_CTRL_BIT;
            pll_lock_r <= phy_xover_pkg::RST_CTRL_BIT;
            mask_r <= phy_xover_pkg::RST_MASK;
        end else if (port_phy_reset) begin
            src_sel_r <= phy_xover_pkg::RST_CTRL_BIT;
            xover_en_r <= phy_xover_pkg::RST_CTRL_BIT;
            xover_state_r <= phy_xover_pkg::RST_CTRL_BIT;
            hb_disable_r <= phy_xover_pkg::RST_CTRL_BIT;
            pll_lock_r <= phy_xover_pkg::RST_CTRL_BIT;
        end else begin
            if (wr_ctrl) begin
                src_sel_r <= wdata_r[phy_xover_pkg::POS_XOVER_SOURCE_SELECT];
                xover_en_r <= wdata_r[phy_xover_pkg::POS_XOVER_ENABLE];
                xover_state_r <= wdata_r[phy_xover_pkg::POS_XOVER_STATE];
                hb_disable_r <= wdata_r[phy_xover_pkg::POS_HEARTBEAT_TEST_DISABLE];
                pll_lock_r <= wdata_r[phy_xover_pkg::POS_RX_PLL_FORCE_REF_LOCK];
            end
            if (wr_mask) begin
                mask_r <= wdata_r[phy_xover_pkg::FLAG_HI:phy_xover_pkg::FLAG_LO];
            end
        end
    end

    // ------------------------------------------------------------------
    // Crossover decode and PHY control outputs
    // ------------------------------------------------------------------
    // The reserved enable-and-state pair is not trapped; it decodes as automatic.
    logic [1:0] reg_mode;
    logic [1:0] strap_mode;
    logic [1:0] mode_nxt;

    assign reg_mode = xover_en_r ? phy_xover_pkg::MDIX_AUTO
                    : (xover_state_r ? phy_xover_pkg::MDIX_CROSS : phy_xover_pkg::MDIX_STRAIGHT);
    assign strap_mode = auto_mdix_strap ? phy_xover_pkg::MDIX_AUTO
                      : (manual_mdix_strap ? phy_xover_pkg::MDIX_CROSS : phy_xover_pkg::MDIX_STRAIGHT);
    assign mode_nxt = src_sel_r ? reg_mode : strap_mode;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mdix_mode <= phy_xover_pkg::MDIX_STRAIGHT;
            heartbeat_test_en <= 1'b1;
            rx_pll_ref_lock <= 1'b0;
            rx10_valid_out <= 1'b0;
        end else begin
            mdix_mode <= mode_nxt;
            heartbeat_test_en <= !hb_disable_r;
            rx_pll_ref_lock <= pll_lock_r;
            rx10_valid_out <= rx10_valid_in && !pll_lock_r;
        end
    end

    // ------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------
    logic ar_take;
    logic [5:0] rd_idx;
    logic rd_clear;
    logic [6:0] events;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[phy_xover_pkg::ADDR_W-1:2];
    assign rd_clear = ar_take && rd_idx == phy_xover_pkg::IDX_EVENT_FLAGS;
    assign events[phy_xover_pkg::POS_FLAG_LINE_ENERGY-1] = line_energy_detect && !energy_prev_r;
    assign events[phy_xover_pkg::POS_FLAG_AUTONEG_COMPLETE-1] = autoneg_complete_evt;
    assign events[phy_xover_pkg::POS_FLAG_REMOTE_FAULT-1] = remote_fault_evt;
    assign events[phy_xover_pkg::POS_FLAG_LINK_DOWN-1] = !link_status && link_prev_r;
    assign events[phy_xover_pkg::POS_FLAG_PARTNER_ACK-1] = partner_ack_evt;
    assign events[phy_xover_pkg::POS_FLAG_PARALLEL_DETECT_FAULT-1] = parallel_detect_fault_evt;
    assign events[phy_xover_pkg::POS_FLAG_PAGE_RECEIVED-1] = page_received_evt;
    // A new enabled event wins over the clearing read in the same cycle.
    assign flags_nxt = (rd_clear ? phy_xover_pkg::RST_FLAGS : flags_r) | (events & mask_r);

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_r <= phy_xover_pkg::RST_FLAGS;
            energy_prev_r <= 1'b0;
            link_prev_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            energy_prev_r <= line_energy_detect;
            link_prev_r <= link_status;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic [15:0] ctrl_rd;
    logic [15:0] flags_rd;
    logic [15:0] mask_rd;
    logic rd_hit;
    logic [31:0] rd_word;

    // Reserved positions are built as constant zeros.
    assign ctrl_rd = {src_sel_r, xover_en_r, xover_state_r, 1'b0, hb_disable_r, pll_lock_r, 5'h00,
                      rx_polarity_reversed_in, 4'h0};
    assign flags_rd = {8'h00, flags_r, 1'b0};
    assign mask_rd = {8'h00, mask_r, 1'b0};
    assign rd_hit = rd_idx == phy_xover_pkg::IDX_XOVER_CTRL || rd_idx == phy_xover_pkg::IDX_EVENT_FLAGS
                    || rd_idx == phy_xover_pkg::IDX_EVENT_MASK;
    assign rd_word = rd_idx == phy_xover_pkg::IDX_XOVER_CTRL ? {16'h0000, ctrl_rd}
                   : rd_idx == phy_xover_pkg::IDX_EVENT_FLAGS ? {16'h0000, flags_rd}
                   : rd_idx == phy_xover_pkg::IDX_EVENT_MASK ? {16'h0000, mask_rd} : 32'h0;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= phy_xover_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? phy_xover_pkg::RESP_OKAY : phy_xover_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

//--- testbench/phy_crossover_and_event_flags_monitor.sv
// Checker for the crossover control and event flag register bank, watching top-level ports only.
// Assumes it is bound into phy_crossover_and_event_flags and shares its clock and reset.
`timescale 1ns/1ns
module phy_crossover_and_event_flags_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // PHY side
    input wire logic port_phy_reset,
    input wire logic rx10_valid_in,
    input wire logic rx10_valid_out,
    input wire logic [1:0] mdix_mode,
    input wire logic heartbeat_test_en,
    input wire logic rx_pll_ref_lock,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Counts edges since reset release so the synchronised inner reset is over before checking.
    logic [2:0] up_r;
    wire settled = (up_r == 3'h7);
    wire [5:0] ar_idx = s_axi_araddr[7:2];
    wire ar_mapped = (ar_idx == 6'h1b) || (ar_idx == 6'h1d) || (ar_idx == 6'h1e);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 3'h0;
        end else if (!settled) begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_lock_blocks_rx: assert property (settled && rx_pll_ref_lock && $past(rx_pll_ref_lock) |-> !rx10_valid_out)
        else $error("receive data passed while the reference lock was forced");
    chk_rx_passes: assert property (settled && !rx_pll_ref_lock |=> !rx_pll_ref_lock |-> rx10_valid_out == $past(rx10_valid_in))
        else $error("receive valid not passed one cycle late");
    chk_mode_legal: assert property (mdix_mode != 2'h3)
        else $error("crossover mode has an undefined code");
    chk_port_reset_defaults: assert property (settled && port_phy_reset |=> ##1 heartbeat_test_en && !rx_pll_ref_lock)
        else $error("port reset did not restore control defaults");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && !ar_mapped |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && !s_axi_rdata[0])
        else $error("reserved read bits not zero");
endmodule
bind phy_crossover_and_event_flags phy_crossover_and_event_flags_checker i_phy_crossover_and_event_flags_checker (
    .core_clk, .rst_n, .port_phy_reset, .rx10_valid_in, .rx10_valid_out, .mdix_mode, .heartbeat_test_en,
    .rx_pll_ref_lock, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

//--- testbench/phy_crossover_and_event_flags_test.sv
// Self-checking bench for the crossover control and event flag register bank.
// Assumes the design package is compiled first; the bench acts as AXI4-Lite master and PHY.
`timescale 1ns/1ns
module phy_crossover_and_event_flags_test;
    logic core_clk = 1'b0, rst_n = 1'b0, port_phy_reset = 1'b0, auto_mdix_strap = 1'b0, manual_mdix_strap = 1'b0;
    logic rx_polarity_reversed_in = 1'b0, line_energy_detect = 1'b0, link_status = 1'b1, autoneg_complete_evt = 1'b0;
    logic remote_fault_evt = 1'b0, partner_ack_evt = 1'b0, parallel_detect_fault_evt = 1'b0, page_received_evt = 1'b0;
    logic rx10_valid_in = 1'b0, rx10_valid_out, heartbeat_test_en, rx_pll_ref_lock;
    logic [1:0] mdix_mode, s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int n_fail = 0, n_checks = 0, cycles = 0;
    phy_crossover_and_event_flags i_phy_crossover_and_event_flags (.core_clk, .rst_n, .port_phy_reset,
        .auto_mdix_strap, .manual_mdix_strap, .rx_polarity_reversed_in, .line_energy_detect, .link_status,
        .autoneg_complete_evt, .remote_fault_evt, .partner_ack_evt, .parallel_detect_fault_evt, .page_received_evt,
        .rx10_valid_in, .rx10_valid_out, .mdix_mode, .heartbeat_test_en, .rx_pll_ref_lock, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #5 core_clk = ~core_clk;
    // ------------------------------------------------------------------
    // Verdict, watchdog and shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done = 0, w_done = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) aw_done = 1;
            if (s_axi_wvalid && s_axi_wready) w_done = 1;
            if (aw_done) s_axi_awvalid <= 1'b0;
            if (w_done) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b1;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // A set pulse fires a page-received event in the cycle the read address is offered.
    task automatic axi_read(input logic [7:0] a, input bit pulse, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        page_received_evt <= pulse;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        page_received_evt <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic fire_events();
        @(posedge core_clk);
        {line_energy_detect, autoneg_complete_evt, remote_fault_evt} <= 3'h7;
        {link_status, partner_ack_evt, parallel_detect_fault_evt, page_received_evt} <= 4'h7;
        @(posedge core_clk);
        {line_energy_detect, autoneg_complete_evt, remote_fault_evt} <= 3'h0;
        {link_status, partner_ack_evt, parallel_detect_fault_evt, page_received_evt} <= 4'h8;
        repeat (2) @(posedge core_clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_values();
        axi_read(8'h6c, 0, rd, resp);
        chk("ctrl reset", 32'h0, rd);
        axi_read(8'h74, 0, rd, resp);
        chk("flags reset", 32'h0, rd);
        axi_read(8'h78, 0, rd, resp);
        chk("mask reset", 32'h0, rd);
        chk("heartbeat on", 32'h1, {31'h0, heartbeat_test_en});
    endtask
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {auto_mdix_strap, manual_mdix_strap} <= i[1:0];
            repeat (3) @(posedge core_clk);
            chk("strap mode", (i > 1) ? 32'h2 : i, {30'h0, mdix_mode});
        end
    endtask
    task automatic t_register_mode();
        logic [31:0] wr [4] = '{32'h8000, 32'ha000, 32'hc000, 32'h2000};
        logic [31:0] ex [4] = '{32'h0, 32'h1, 32'h2, 32'h2};
        for (int i = 0; i < 4; i++) begin
            axi_write(8'h6c, wr[i], resp);
            repeat (2) @(posedge core_clk);
            chk("register mode", ex[i], {30'h0, mdix_mode});
        end
    endtask
    task automatic t_misc_and_port_reset();
        rx_polarity_reversed_in <= 1'b1;
        rx10_valid_in <= 1'b1;
        axi_write(8'h6c, 32'h0000bfff, resp);
        repeat (2) @(posedge core_clk);
        axi_read(8'h6c, 0, rd, resp);
        chk("ctrl readback", 32'hac10, rd);
        chk("heartbeat off", 32'h0, {31'h0, heartbeat_test_en});
        chk("pll lock", 32'h1, {31'h0, rx_pll_ref_lock});
        chk("rx blocked", 32'h0, {31'h0, rx10_valid_out});
        @(posedge core_clk);
        port_phy_reset <= 1'b1;
        @(posedge core_clk);
        port_phy_reset <= 1'b0;
        axi_read(8'h6c, 0, rd, resp);
        chk("ctrl after port reset", 32'h10, rd);
        chk("rx passes", 32'h1, {31'h0, rx10_valid_out});
    endtask
    task automatic t_events();
        axi_write(8'h78, 32'hffff, resp);
        axi_read(8'h78, 0, rd, resp);
        chk("mask readback", 32'hfe, rd);
        fire_events();
        axi_read(8'h74, 0, rd, resp);
        chk("all flags", 32'hfe, rd);
        axi_write(8'h74, 32'h0, resp);
        axi_read(8'h74, 0, rd, resp);
        chk("flags cleared", 32'h0, rd);
        axi_write(8'h78, 32'h02, resp);
        fire_events();
        axi_read(8'h74, 1, rd, resp);
        chk("masked flags", 32'h02, rd);
        axi_read(8'h74, 0, rd, resp);
        chk("event in clearing read", 32'h02, rd);
    endtask
    task automatic t_unmapped();
        axi_write(8'h40, 32'hffff, resp);
        chk("unmapped write resp", 32'h2, {30'h0, resp});
        axi_read(8'h40, 0, rd, resp);
        chk("unmapped read resp", 32'h2, {30'h0, resp});
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset_values();
        t_straps();
        t_register_mode();
        t_misc_and_port_reset();
        t_events();
        t_unmapped();
        give_verdict();
    end
endmodule
